// [rtl/pit_pkg.sv]
// Constants, field layouts and state types of the three-channel interval timer.
// Assumes one core clock; all pin-side inputs except rst are synchronised inside the top module.
package pit_pkg;

  // ----------------------------------------------------------------
  // Sizes and addressing
  // ----------------------------------------------------------------
  localparam int         NUM_CNT      = 3;
  localparam int         CNT_W        = 16;
  localparam logic [1:0] CW_ADDR      = 2'h3;
  localparam logic [1:0] SEL_READBACK = 2'h3;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int SEL_HI           = 7;
  localparam int SEL_LO           = 6;
  localparam int LOAD_FORMAT_HIGH = 5;
  localparam int LOAD_FORMAT_LOW  = 4;
  localparam int MODE_HI          = 3;
  localparam int MODE_LO          = 1;
  localparam int BCD_BIT          = 0;
  localparam int RB_NO_COUNT      = 5;
  localparam int RB_NO_STATUS     = 4;
  localparam int RB_SEL_LO        = 1;
  localparam int CTRL_W           = 6;

  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW   = 2'h1;
  localparam logic [1:0] FMT_HIGH  = 2'h2;
  localparam logic [1:0] FMT_BOTH  = 2'h3;

  localparam logic [2:0] MODE0 = 3'h0;
  localparam logic [2:0] MODE1 = 3'h1;
  localparam logic [2:0] MODE2 = 3'h2;
  localparam logic [2:0] MODE3 = 3'h3;
  localparam logic [2:0] MODE4 = 3'h4;
  localparam logic [2:0] MODE5 = 3'h5;

  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [3:0]  BCD_NINE  = 4'h9;
  localparam logic [3:0]  BCD_ZERO  = 4'h0;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       count;
    logic [15:0]       init;
    logic [15:0]       latch;
    logic [7:0]        status;
    logic [CTRL_W-1:0] ctrl;
    logic              latched;
    logic              stlat;
    logic              wr_hi;
    logic              rd_hi;
    logic              load;
    logic              nul;
    logic              armed;
    logic              trig;
    logic              out;
  } pit_cnt_s;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [1:0] addr;
    logic [7:0] data;
  } pit_bus_s;

  localparam pit_bus_s BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 2'h0, data: 8'h00};

  typedef struct packed {
    pit_cnt_s [NUM_CNT-1:0] cnt;
    pit_bus_s               bs1;
    pit_bus_s               bs2;
    pit_bus_s               bs3;
    logic [NUM_CNT-1:0]     ck1;
    logic [NUM_CNT-1:0]     ck2;
    logic [NUM_CNT-1:0]     ck3;
    logic [NUM_CNT-1:0]     gt1;
    logic [NUM_CNT-1:0]     gt2;
    logic [NUM_CNT-1:0]     gt3;
    logic [7:0]             dout;
    logic                   oe;
  } pit_state_s;

endpackage

// [rtl/pit_top.sv]
// Three-channel programmable interval timer with its 8-bit parallel host port.
// Assumes all pins (strobes, data, counter clocks, gates) are asynchronous to core_clk
// and change slowly against it; each passes at least two flip-flops before use, and write data and address three.
`timescale 1ns/10ps

module pit_top
  import pit_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        cs_n,
  input  wire logic                        rd_n,
  input  wire logic                        wr_n,
  input  wire logic [1:0]                  addr,
  input  wire logic [7:0]                  data_in,
  output logic      [7:0]                  data_out,
  output logic                             data_oe,
  input  wire logic [pit_pkg::NUM_CNT-1:0] cnt_clk,
  input  wire logic [pit_pkg::NUM_CNT-1:0] gate,
  output logic      [pit_pkg::NUM_CNT-1:0] cnt_out
);
  import pit_pkg::*;

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  pit_state_s q;
  pit_state_s d;
  logic       wr_end;
  logic       rd_end;
  logic       cw_wr;

  // A strobe is acted on at its trailing edge, when data and address are settled.
  assign wr_end = !q.bs3.cs_n && !q.bs3.wr_n && q.bs2.wr_n;
  assign rd_end = !q.bs3.cs_n && !q.bs3.rd_n && q.bs2.rd_n;
  assign cw_wr  = wr_end && (q.bs3.addr == CW_ADDR);

  // One step down; BCD borrows digit by digit, so zero wraps to 9999.
  function automatic logic [15:0] pit_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        brw;
    r   = v - CNT_ONE;
    brw = 1'b1;
    if (bcd) begin
      r = v;
      for (int k = 0; k < 4; k++) begin
        if (brw) begin
          if (v[k*4 +: 4] == BCD_ZERO) begin
            r[k*4 +: 4] = BCD_NINE;
          end else begin
            r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pit_cnt_s    c;
    pit_cnt_s    rc;
    logic        fall;
    logic        en;
    logic [2:0]  md;
    logic [1:0]  fmt;
    logic [15:0] nx;
    logic [15:0] nx2;
    logic [15:0] src;
    logic [7:0]  cw;
    c    = '0;
    rc   = '0;
    fall = 1'b0;
    en   = 1'b0;
    md   = MODE0;
    fmt  = FMT_LATCH;
    nx   = CNT_ZERO;
    nx2  = CNT_ZERO;
    src  = CNT_ZERO;
    cw   = q.bs3.data;
    d    = q;

    d.bs1.cs_n = cs_n;
    d.bs1.rd_n = rd_n;
    d.bs1.wr_n = wr_n;
    d.bs1.addr = addr;
    d.bs1.data = data_in;
    d.bs2      = q.bs1;
    d.bs3      = q.bs2;
    d.ck1      = cnt_clk;
    d.ck2      = q.ck1;
    d.ck3      = q.ck2;
    d.gt1      = gate;
    d.gt2      = q.gt1;
    d.gt3      = q.gt2;

    for (int i = 0; i < NUM_CNT; i++) begin
      c    = q.cnt[i];
      fall = q.ck3[i] && !q.ck2[i];
      md   = c.ctrl[MODE_HI:MODE_LO];
      // Codes 6 and 7 alias modes 2 and 3.
      if (md[1]) begin
        md = {1'b0, md[1:0]};
      end
      fmt = c.ctrl[LOAD_FORMAT_HIGH:LOAD_FORMAT_LOW];
      en  = (md == MODE1 || md == MODE5) ? 1'b1 : q.gt2[i];
      nx  = pit_dec(c.count, c.ctrl[BCD_BIT]);
      nx2 = pit_dec(nx, c.ctrl[BCD_BIT]);

      // Gate edges: triggers for one-shots, restart for the rate modes.
      if (q.gt2[i] && !q.gt3[i] && md != MODE0 && md != MODE4) begin
        c.trig = 1'b1;
      end
      if (!q.gt2[i] && (md == MODE2 || md == MODE3)) begin
        c.out = 1'b1;
      end

      // Counter clock edge; runs whatever the chip select does.
      if (fall) begin
        if (md == MODE4 || md == MODE5) begin
          c.out = 1'b1;
        end
        if (c.trig && !c.nul) begin
          c.count = c.init;
          c.armed = 1'b1;
          c.trig  = 1'b0;
          c.load  = 1'b0;
          if (md == MODE1) begin
            c.out = 1'b0;
          end
        end else if (c.load && md != MODE1 && md != MODE5) begin
          c.count = c.init;
          c.armed = 1'b1;
          c.load  = 1'b0;
          c.nul   = 1'b0;
        end else if (c.armed && en) begin
          case (md)
            MODE0, MODE1: begin
              c.count = nx;
              if (nx == CNT_ZERO) begin
                c.out = 1'b1;
              end
            end
            MODE2: begin
              if (c.count == CNT_ONE) begin
                c.count = c.init;
                c.out   = 1'b1;
              end else begin
                c.count = nx;
                c.out   = (nx != CNT_ONE);
              end
            end
            MODE3: begin
              if (nx == CNT_ZERO || nx2 == CNT_ZERO) begin
                c.count = c.init;
                c.out   = !c.out;
              end else begin
                c.count = nx2;
              end
            end
            default: begin
              c.count = nx;
              if (nx == CNT_ZERO) begin
                c.out   = 1'b0;
                c.armed = 1'b0;
              end
            end
          endcase
        end
        if (c.trig && c.nul) begin
          c.trig = 1'b0;
        end
      end

      // Host byte written to this counter.
      if (wr_end && q.bs3.addr == 2'(i)) begin
        case (fmt)
          FMT_LOW: begin
            c.init = {BYTE_ZERO, q.bs3.data};
            c.load = 1'b1;
            c.nul  = 1'b1;
          end
          FMT_HIGH: begin
            c.init = {q.bs3.data, BYTE_ZERO};
            c.load = 1'b1;
            c.nul  = 1'b1;
          end
          FMT_BOTH: begin
            if (!c.wr_hi) begin
              c.init[7:0] = q.bs3.data;
              c.wr_hi     = 1'b1;
              if (md == MODE0) begin
                c.armed = 1'b0;
              end
            end else begin
              c.init[15:8] = q.bs3.data;
              c.wr_hi      = 1'b0;
              c.load       = 1'b1;
              c.nul        = 1'b1;
            end
          end
          default: begin
          end
        endcase
        if (c.load && md == MODE0) begin
          c.out = 1'b0;
        end
      end

      // Host read of this counter finished: advance the byte order.
      if (rd_end && q.bs3.addr == 2'(i)) begin
        if (c.stlat) begin
          c.stlat = 1'b0;
        end else if (fmt == FMT_BOTH && !c.rd_hi) begin
          c.rd_hi = 1'b1;
        end else begin
          c.rd_hi   = 1'b0;
          c.latched = 1'b0;
        end
      end

      // Control word: read-back, latch command or reprogramming.
      if (cw_wr) begin
        if (cw[SEL_HI:SEL_LO] == SEL_READBACK) begin
          if (cw[RB_SEL_LO + i]) begin
            // A second read-back before the read leaves the first snapshot alone.
            if (!cw[RB_NO_COUNT] && !c.latched) begin
              c.latch   = c.count;
              c.latched = 1'b1;
            end
            if (!cw[RB_NO_STATUS] && !c.stlat) begin
              c.status = {c.out, c.nul, c.ctrl};
              c.stlat  = 1'b1;
            end
          end
        end else if (cw[SEL_HI:SEL_LO] == 2'(i)) begin
          if (cw[LOAD_FORMAT_HIGH:LOAD_FORMAT_LOW] == FMT_LATCH) begin
            if (!c.latched) begin
              c.latch   = c.count;
              c.latched = 1'b1;
            end
          end else begin
            c.ctrl    = cw[CTRL_W-1:0];
            c.out     = (cw[MODE_HI:MODE_LO] != MODE0);
            c.armed   = 1'b0;
            c.load    = 1'b0;
            c.trig    = 1'b0;
            c.nul     = 1'b1;
            c.wr_hi   = 1'b0;
            c.rd_hi   = 1'b0;
            c.latched = 1'b0;
            c.stlat   = 1'b0;
          end
        end
      end
      d.cnt[i] = c;
    end

    // Read data path; the control word address reads as zero.
    d.oe   = !q.bs2.cs_n && !q.bs2.rd_n;
    d.dout = BYTE_ZERO;
    if (q.bs2.addr != CW_ADDR) begin
      rc  = q.cnt[q.bs2.addr];
      src = rc.latched ? rc.latch : rc.count;
      fmt = rc.ctrl[LOAD_FORMAT_HIGH:LOAD_FORMAT_LOW];
      if (rc.stlat) begin
        d.dout = rc.status;
      end else if (fmt == FMT_HIGH || (fmt == FMT_BOTH && rc.rd_hi)) begin
        d.dout = src[15:8];
      end else begin
        d.dout = src[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q     <= '0;
      q.bs1 <= BUS_IDLE;
      q.bs2 <= BUS_IDLE;
      q.bs3 <= BUS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign data_out = q.dout;
  assign data_oe  = q.oe;
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_out
    assign cnt_out[g] = q.cnt[g].out;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  cs_release_a: assert property (@(posedge core_clk) disable iff (rst)
    q.bs2.cs_n |=> !data_oe)
    else $error("data driven while deselected");
  cs_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
    (q.bs3.cs_n && !q.bs3.wr_n && q.bs2.wr_n) |=> $stable(q.cnt[0].ctrl))
    else $error("write taken while deselected");
  mode0_low_a: assert property (@(posedge core_clk) disable iff (rst)
    (cw_wr && q.bs3.data[SEL_HI:SEL_LO] == 2'h0
     && q.bs3.data[LOAD_FORMAT_HIGH:LOAD_FORMAT_LOW] != FMT_LATCH
     && q.bs3.data[MODE_HI:MODE_LO] == MODE0) |=> !cnt_out[0] && q.cnt[0].nul)
    else $error("mode 0 output not low after control word");
  tc_high_a: assert property (@(posedge core_clk) disable iff (rst)
    (q.cnt[0].ctrl[MODE_HI:MODE_LO] == MODE0 && q.cnt[0].armed && q.gt2[0]
     && q.ck3[0] && !q.ck2[0] && !q.cnt[0].load && !wr_end
     && q.cnt[0].count == CNT_ONE) |=> cnt_out[0] ##1 cnt_out[0])
    else $error("mode 0 output not high at terminal count");
  gate_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (q.cnt[0].ctrl[MODE_HI:MODE_LO] == MODE0 && !q.gt2[0] && !q.cnt[0].load
     && !q.cnt[0].trig && !cw_wr) |=> $stable(q.cnt[0].count))
    else $error("mode 0 counted with gate low");
  halt_first_a: assert property (@(posedge core_clk) disable iff (rst)
    (wr_end && q.bs3.addr == 2'h0 && q.cnt[0].ctrl[MODE_HI:MODE_LO] == MODE0
     && q.cnt[0].ctrl[LOAD_FORMAT_HIGH:LOAD_FORMAT_LOW] == FMT_BOTH && !q.cnt[0].wr_hi)
    |=> !q.cnt[0].armed && q.cnt[0].wr_hi)
    else $error("first byte did not halt mode 0");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (q.cnt[0].latched && !rd_end && !cw_wr) |=> q.cnt[0].latched && $stable(q.cnt[0].latch))
    else $error("latched count moved before read");
  readback_a: assert property (@(posedge core_clk) disable iff (rst)
    (cw_wr && q.bs3.data[SEL_HI:SEL_LO] == SEL_READBACK && q.bs3.data[RB_SEL_LO]
     && !q.bs3.data[RB_NO_COUNT] && !q.cnt[0].latched)
    |=> q.cnt[0].latched && q.cnt[0].latch == $past(q.cnt[0].count))
    else $error("read-back did not latch counter 0");
  wrap_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (q.cnt[0].armed && q.ck3[0] && !q.ck2[0] && q.gt2[0] && !q.cnt[0].load && !q.cnt[0].trig
     && !cw_wr && !wr_end && q.cnt[0].count == CNT_ZERO
     && q.cnt[0].ctrl[MODE_HI:MODE_LO] == MODE0)
    |=> q.cnt[0].count == (q.cnt[0].ctrl[BCD_BIT] ? 16'h9999 : 16'hFFFF))
    else $error("zero did not wrap to full range");

endmodule // pit_top

// [tb/pit_host_model.sv]
// Behavioural 8-bit host CPU that drives the timer's parallel port.
// Assumes its wr and rd tasks are called one at a time from one bench process.
`timescale 1ns/10ps
module pit_host_model (
  input  wire logic       core_clk,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [1:0]      addr,
  output wire logic [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            rd_valid,
  output logic [7:0]      rd_byte
);
  logic       drv_en;
  logic [7:0] drv_d;
  logic [7:0] last_q;

  // ----------------------------------------------------------------
  // Shared data bus
  // ----------------------------------------------------------------
  // A floating bus shows the inverse of its last level, so stale data never looks valid.
  assign data_in = data_oe ? data_out : (drv_en ? drv_d : ~last_q);
  always @(posedge core_clk) begin
    if (data_oe || drv_en) begin
      last_q <= data_in;
    end
  end

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 2'h0;
    drv_en = 1'b0;
    drv_d = 8'h00;
    last_q = 8'h00;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // With sel low the whole write runs with the chip deselected and must be ignored.
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic sel);
    @(posedge core_clk);
    #1;
    cs_n = ~sel;
    wr_n = 1'b0;
    addr = a;
    drv_d = d;
    drv_en = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    wr_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cs_n = 1'b1;
    drv_en = 1'b0;
  endtask

  // With sel low the byte returned is the data_oe level seen, which must stay 0.
  task automatic rd(input logic [1:0] a, input logic sel);
    int i;
    @(posedge core_clk);
    #1;
    cs_n = ~sel;
    rd_n = 1'b0;
    addr = a;
    for (i = 0; i < 8 && data_oe !== 1'b1; i++) @(posedge core_clk);
    rd_byte = sel ? data_out : {7'h00, data_oe};
    #1;
    rd_valid = 1'b1;
    rd_n = 1'b1;
    @(posedge core_clk);
    #1;
    rd_valid = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    cs_n = 1'b1;
  endtask
endmodule // pit_host_model

// [tb/programmable_interval_timer_bench.sv]
// Self-checking bench of the three-channel interval timer.
// Assumes pit_top and the host model; counter clocks and gates are driven here.
`timescale 1ns/10ps
module programmable_interval_timer_bench;
  import pit_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [2:0]  cnt_clk;
  logic [2:0]  gate;
  logic [2:0]  cnt_out;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic [1:0]  addr;
  logic [7:0]  data_in;
  logic [7:0]  data_out;
  logic        data_oe;
  logic        rd_valid;
  logic [7:0]  rd_byte;
  logic [7:0]  lfsr_q;
  logic [15:0] mon_e;
  logic [15:0] exp_q[$];
  int          mismatches;
  int          num_checks;

  pit_top i_pit_top (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .cnt_clk(cnt_clk), .gate(gate), .cnt_out(cnt_out));
  pit_host_model i_pit_host_model (.core_clk(core_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rd_valid(rd_valid), .rd_byte(rd_byte));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic rdm(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    i_pit_host_model.rd(a, 1'b1);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    rdm(a, e, 8'hFF);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_pit_host_model.wr(a, d, 1'b1);
  endtask

  task automatic cw(input logic [1:0] c, input logic [1:0] f, input logic [2:0] m, input logic b);
    wr(CW_ADDR, {c, f, m, b});
  endtask

  // Each counter clock level lasts at least four core cycles; the task ends off the edge.
  task automatic tick(input int c, input int k);
    repeat (k) begin
      @(posedge core_clk);
      #1;
      cnt_clk[c] = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      cnt_clk[c] = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask

  task automatic chk(input logic [1:0] c, input logic [15:0] v);
    cw(c, FMT_LATCH, MODE0, 1'b0);
    rd(c, v[7:0]);
    rd(c, v[15:8]);
  endtask

  task automatic rbs(input logic [1:0] c, input logic [7:0] e, input logic [7:0] m);
    wr(CW_ADDR, 8'hE0 | (8'h02 << c));
    rdm(c, e, m);
  endtask

  task automatic chk_out(input int c, input logic v);
    num_checks++;
    if (cnt_out[c] !== v) begin
      mismatches++;
      $display("[ERR] t=%0t out=%h exp=%h", $time, cnt_out[c], v);
    end
  endtask

  task automatic summarize();
    if (exp_q.size() != 0) begin
      mismatches++;
    end
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      mon_e = exp_q.pop_front();
      num_checks++;
      if (((rd_byte ^ mon_e[7:0]) & mon_e[15:8]) !== 8'h00) begin
        mismatches++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, rd_byte, mon_e[7:0]);
      end
    end
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int c;
    logic [15:0] n;
    rst = 1'b1;
    cnt_clk = 3'h0;
    gate = 3'h7;
    lfsr_q = 8'h22;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rd(CW_ADDR, 8'h00);
    exp_q.push_back(16'hFF00);
    i_pit_host_model.rd(2'h0, 1'b0);
    for (c = 0; c < NUM_CNT; c++) begin
      lfsr_q = lfsr_next(lfsr_q);
      n = {8'h00, 8'h03 + {5'h00, lfsr_q[2:0]}};
      cw(c[1:0], FMT_BOTH, MODE0, 1'b0);
      rbs(c[1:0], 8'h70, 8'hFF);
      chk_out(c, 1'b0);
      wr(c[1:0], n[7:0]);
      wr(c[1:0], n[15:8]);
      tick(c, 2);
      cw(c[1:0], FMT_LATCH, MODE0, 1'b0);
      // The counter steps while the host holds the chip selected for a read.
      fork
        tick(c, 1);
        rd(c[1:0], n[7:0] - 8'h01);
      join
      rd(c[1:0], 8'h00);
      rd(c[1:0], n[7:0] - 8'h02);
      rd(c[1:0], 8'h00);
      gate[c] = 1'b0;
      tick(c, 2);
      gate[c] = 1'b1;
      chk(c[1:0], n - 16'h0002);
      tick(c, int'(n) - 2);
      rbs(c[1:0], 8'hB0, 8'hFF);
      chk_out(c, 1'b1);
      tick(c, 2);
      chk_out(c, 1'b1);
      wr(c[1:0], 8'h05);
      tick(c, 2);
      chk(c[1:0], 16'hFFFE);
      wr(c[1:0], 8'h00);
      tick(c, 2);
      chk_out(c, 1'b0);
      chk(c[1:0], 16'h0004);
    end
    cw(2'h1, FMT_BOTH, MODE0, 1'b1);
    wr(2'h1, 8'h00);
    wr(2'h1, 8'h00);
    tick(1, 2);
    chk(2'h1, 16'h9999);
    wr(2'h1, 8'h00);
    wr(2'h1, 8'h01);
    tick(1, 2);
    chk(2'h1, 16'h0099);
    i_pit_host_model.wr(CW_ADDR, 8'h12, 1'b0);
    wr(CW_ADDR, 8'hEE);
    rd(2'h0, 8'h30);
    rd(2'h1, 8'h31);
    rd(2'h2, 8'h30);
    cw(2'h2, FMT_BOTH, MODE0, 1'b0);
    wr(2'h2, 8'h00);
    wr(2'h2, 8'h00);
    tick(2, 2);
    chk(2'h2, 16'hFFFF);
    wr(CW_ADDR, 8'hDE);
    tick(1, 1);
    wr(CW_ADDR, 8'hDE);
    rd(2'h1, 8'h99);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'hFF);
    rd(2'h2, 8'hFF);
    rd(2'h0, 8'h04);
    rd(2'h0, 8'h00);
    cw(2'h2, FMT_LOW, MODE0, 1'b0);
    wr(2'h2, 8'h21);
    tick(2, 1);
    cw(2'h2, FMT_LATCH, MODE0, 1'b0);
    rd(2'h2, 8'h21);
    rd(2'h2, 8'h21);
    cw(2'h2, FMT_HIGH, MODE0, 1'b0);
    wr(2'h2, 8'h12);
    tick(2, 1);
    rd(2'h2, 8'h12);
    for (c = 0; c < 6; c++) begin
      cw(2'h2, FMT_BOTH, c[2:0], 1'b0);
      rbs(2'h2, {2'h1, 2'h3, c[2:0], 1'b0}, 8'h7F);
    end
    // Reset in mid-run: outputs drop and the control word returns to zero.
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk_out(2, 1'b0);
    rbs(2'h2, 8'h00, 8'hFF);
    summarize();
  end
endmodule // programmable_interval_timer_bench
